//--- rtl/mtpwm_pkg.sv
// Purpose: constants and types for the 32-bit match timer with PWM outputs
// Assumes: APB register access, one clock, synchronous active-high reset
// Notes: register offsets are byte addresses on a 32-bit APB data bus
package mtpwm_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam int MTPWM_AW = 8;
    localparam int MTPWM_NCH = 4;
    localparam logic [MTPWM_AW-1:0] MTPWM_RUN_CTRL_ADDR = 8'h00;
    localparam logic [MTPWM_AW-1:0] MTPWM_COUNT_ADDR = 8'h04;
    localparam logic [MTPWM_AW-1:0] MTPWM_SRC_CTRL_ADDR = 8'h10;
    localparam logic [MTPWM_AW-1:0] MTPWM_MATCH_CTRL_ADDR = 8'h14;
    localparam logic [MTPWM_AW-1:0] MTPWM_CMP0_ADDR = 8'h18;
    localparam logic [MTPWM_AW-1:0] MTPWM_CMP3_ADDR = 8'h24;
    localparam logic [MTPWM_AW-1:0] MTPWM_PWM_EN_ADDR = 8'h34;

    // ****************************************
    // field positions and widths
    // ****************************************
    localparam int MTPWM_RUN_BIT = 0;
    localparam int MTPWM_CLR_BIT = 1;
    localparam int MTPWM_EDGE_LSB = 0;
    localparam int MTPWM_PICK_LSB = 2;
    localparam int MTPWM_SRC_W = 4;
    localparam int MTPWM_IRQ_BIT0 = 0;
    localparam int MTPWM_RESTART_BIT0 = 1;
    localparam int MTPWM_HALT_BIT0 = 2;
    localparam int MTPWM_MCH_STRIDE = 3;
    localparam int MTPWM_MACT_W = 12;

    // ****************************************
    // reset values
    // ****************************************
    localparam logic [31:0] MTPWM_COUNT_RST = 32'h0000_0000;
    localparam logic [31:0] MTPWM_CMP_RST = 32'h0000_0000;
    localparam logic [MTPWM_SRC_W-1:0] MTPWM_SRC_RST = 4'h0;
    localparam logic [MTPWM_MACT_W-1:0] MTPWM_MACT_RST = 12'h000;
    localparam logic [1:0] MTPWM_PICK_CAP0 = 2'h0;

    typedef enum logic [1:0] {
        MTPWM_TIMER = 2'h0,
        MTPWM_RISE = 2'h1,
        MTPWM_FALL = 2'h2,
        MTPWM_BOTH = 2'h3
    } mtpwm_edge_t;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [MTPWM_AW-1:0] paddr;
        logic [31:0] pwdata;
    } mtpwm_apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } mtpwm_apb_rsp_t;

endpackage

//--- rtl/mtpwm_edge.sv
// Purpose: synchronises the count input and turns it into count events
// Assumes: input comes from a pin, outside the clock domain
// Notes: event is combinational from flops, one cycle wide
`timescale 1ns/10ps
module mtpwm_edge
    import mtpwm_pkg::*;
(
    input wire logic clk_in,
    input wire logic reset_in,
    input wire logic pin_in,
    input wire mtpwm_edge_t mode_in,
    input wire logic pick_ok_in,
    output logic tick_out
);

    logic sync1_q;
    logic sync2_q;
    logic prev_q;
    logic rise;
    logic fall;

    // ****************************************
    // two-flop synchroniser, then one older sample
    // ****************************************
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            sync1_q <= pin_in;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
        end
    end

    // two successive samples classify the edge
    assign rise = sync2_q & ~prev_q;
    assign fall = ~sync2_q & prev_q;

    // reserved input codes select nothing, so the edge modes keep the count put; timer mode still counts
    always_comb begin
        case (mode_in)
            MTPWM_TIMER: tick_out = 1'b1;
            MTPWM_RISE: tick_out = pick_ok_in & rise;
            MTPWM_FALL: tick_out = pick_ok_in & fall;
            MTPWM_BOTH: tick_out = pick_ok_in & (rise | fall);
            default: tick_out = 1'b0;
        endcase
    end

endmodule

//--- rtl/mtpwm_top.sv
// Purpose: 32-bit match timer with four compare channels and PWM outputs
// Assumes: APB slave with no wait states, 100 MHz clock
// Notes: read data is the snapshot taken in the APB setup cycle
`timescale 1ns/10ps
module mtpwm_top
    import mtpwm_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RESET_IN,
    input wire mtpwm_apb_req_t APB_IN,
    output mtpwm_apb_rsp_t APB_OUT,
    input wire logic CAP_IN,
    output logic [MTPWM_NCH-1:0] PWM_OUT,
    output logic [MTPWM_NCH-1:0] MATCH_IRQ_OUT
);

    // ****************************************
    // state
    // ****************************************
    logic run_q;
    logic clr_q;
    logic [31:0] tc_q;
    logic [31:0] tc_d;
    logic [MTPWM_SRC_W-1:0] src_q;
    logic [MTPWM_MACT_W-1:0] mact_q;
    logic [31:0] cmp_q [MTPWM_NCH];
    logic [MTPWM_NCH-1:0] pwm_en_q;
    logic [MTPWM_NCH-1:0] pwm_q;
    logic [MTPWM_NCH-1:0] irq_q;
    logic wrap_q;
    logic tc_new_q;
    logic [31:0] prdata_q;
    logic slverr_q;

    logic wr_en;
    logic setup;
    logic tick;
    logic step;
    logic [MTPWM_NCH-1:0] match;
    logic [MTPWM_NCH-1:0] ie_bits;
    logic [MTPWM_NCH-1:0] rs_bits;
    logic [MTPWM_NCH-1:0] hl_bits;
    logic restart_hit;
    logic halt_hit;
    logic wr_run;
    logic wr_tc;
    mtpwm_edge_t mode;

    // ****************************************
    // address decode
    // ****************************************
    function automatic logic is_cmp(input logic [MTPWM_AW-1:0] a);
        return (a >= MTPWM_CMP0_ADDR) && (a <= MTPWM_CMP3_ADDR) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic is_mapped(input logic [MTPWM_AW-1:0] a);
        return (a == MTPWM_RUN_CTRL_ADDR) || (a == MTPWM_COUNT_ADDR)
            || (a == MTPWM_SRC_CTRL_ADDR) || (a == MTPWM_MATCH_CTRL_ADDR)
            || (a == MTPWM_PWM_EN_ADDR) || is_cmp(a);
    endfunction

    function automatic logic [1:0] cmp_idx(input logic [MTPWM_AW-1:0] a);
        logic [MTPWM_AW-1:0] off;
        off = a - MTPWM_CMP0_ADDR;
        return off[3:2];
    endfunction

    assign setup = APB_IN.psel & ~APB_IN.penable;
    assign wr_en = APB_IN.psel & APB_IN.penable & APB_IN.pwrite;
    assign wr_run = wr_en & (APB_IN.paddr == MTPWM_RUN_CTRL_ADDR);
    assign wr_tc = wr_en & (APB_IN.paddr == MTPWM_COUNT_ADDR);
    assign mode = mtpwm_edge_t'(src_q[MTPWM_EDGE_LSB +: 2]);

    // ****************************************
    // count source
    // ****************************************
    mtpwm_edge u_edge (
        .clk_in(CLK_IN),
        .reset_in(RESET_IN),
        .pin_in(CAP_IN),
        .mode_in(mode),
        .pick_ok_in(src_q[MTPWM_PICK_LSB +: 2] == MTPWM_PICK_CAP0),
        .tick_out(tick)
    );

    assign step = run_q & tick;

    // ****************************************
    // compare channels
    // ****************************************
    always_comb begin
        for (int i = 0; i < MTPWM_NCH; i++) begin
            match[i] = (tc_q == cmp_q[i]);
            ie_bits[i] = mact_q[MTPWM_MCH_STRIDE*i + MTPWM_IRQ_BIT0];
            rs_bits[i] = mact_q[MTPWM_MCH_STRIDE*i + MTPWM_RESTART_BIT0];
            hl_bits[i] = mact_q[MTPWM_MCH_STRIDE*i + MTPWM_HALT_BIT0];
        end
    end

    // restart waits for a count event so the matched value lasts one period
    assign restart_hit = step & |(match & rs_bits);
    assign halt_hit = run_q & |(match & hl_bits);

    // ****************************************
    // counter
    // ****************************************
    always_comb begin
        if (clr_q) begin
            tc_d = MTPWM_COUNT_RST;
        end else if (wr_tc) begin
            tc_d = APB_IN.pwdata;
        end else if (restart_hit) begin
            tc_d = MTPWM_COUNT_RST;
        end else if (halt_hit) begin
            tc_d = tc_q;
        end else if (step) begin
            tc_d = tc_q + 32'h0000_0001;
        end else begin
            tc_d = tc_q;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            tc_q <= MTPWM_COUNT_RST;
            tc_new_q <= 1'b0;
            wrap_q <= 1'b0;
        end else begin
            tc_q <= tc_d;
            tc_new_q <= (tc_d != tc_q);
            wrap_q <= clr_q | restart_hit;
        end
    end

    // ****************************************
    // run and clear control
    // ****************************************
    // a software write lands after the halt, so it wins over the hardware clear
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            run_q <= 1'b0;
        end else if (wr_run) begin
            run_q <= APB_IN.pwdata[MTPWM_RUN_BIT];
        end else if (halt_hit) begin
            run_q <= 1'b0;
        end
    end

    // a fresh request in the clearing cycle is kept, set beats clear
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            clr_q <= 1'b0;
        end else if (wr_run && APB_IN.pwdata[MTPWM_CLR_BIT]) begin
            clr_q <= 1'b1;
        end else if (clr_q) begin
            clr_q <= 1'b0;
        end
    end

    // ****************************************
    // configuration registers
    // ****************************************
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            src_q <= MTPWM_SRC_RST;
            mact_q <= MTPWM_MACT_RST;
            pwm_en_q <= '0;
        end else if (wr_en) begin
            if (APB_IN.paddr == MTPWM_SRC_CTRL_ADDR) begin
                src_q <= APB_IN.pwdata[MTPWM_SRC_W-1:0];
            end
            if (APB_IN.paddr == MTPWM_MATCH_CTRL_ADDR) begin
                mact_q <= APB_IN.pwdata[MTPWM_MACT_W-1:0];
            end
            if (APB_IN.paddr == MTPWM_PWM_EN_ADDR) begin
                pwm_en_q <= APB_IN.pwdata[MTPWM_NCH-1:0];
            end
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            for (int i = 0; i < MTPWM_NCH; i++) begin
                cmp_q[i] <= MTPWM_CMP_RST;
            end
        end else if (wr_en && is_cmp(APB_IN.paddr)) begin
            cmp_q[cmp_idx(APB_IN.paddr)] <= APB_IN.pwdata;
        end
    end

    // ****************************************
    // match interrupt requests
    // ****************************************
    // only a freshly reached value raises a request, a held count does not repeat it
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            irq_q <= '0;
        end else begin
            irq_q <= (tc_new_q ? (match & ie_bits) : '0);
        end
    end

    // ****************************************
    // PWM outputs
    // ****************************************
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            pwm_q <= '0;
        end else begin
            for (int i = 0; i < MTPWM_NCH; i++) begin
                if (!pwm_en_q[i]) begin
                    pwm_q[i] <= 1'b0;
                end else if (wrap_q) begin
                    pwm_q[i] <= (cmp_q[i] == 32'h0000_0000);
                end else if (match[i] && (cmp_q[i] != 32'h0000_0000)) begin
                    pwm_q[i] <= 1'b1;
                end
            end
        end
    end

    // ****************************************
    // APB read side
    // ****************************************
    always_ff @(posedge CLK_IN) begin
        if (RESET_IN) begin
            prdata_q <= 32'h0000_0000;
            slverr_q <= 1'b0;
        end else if (setup) begin
            slverr_q <= ~is_mapped(APB_IN.paddr);
            prdata_q <= 32'h0000_0000;
            if (!APB_IN.pwrite) begin
                case (APB_IN.paddr)
                    MTPWM_RUN_CTRL_ADDR: prdata_q <= {30'h0, clr_q, run_q};
                    MTPWM_COUNT_ADDR: prdata_q <= tc_q;
                    MTPWM_SRC_CTRL_ADDR: prdata_q <= {28'h0, src_q};
                    MTPWM_MATCH_CTRL_ADDR: prdata_q <= {20'h0, mact_q};
                    MTPWM_PWM_EN_ADDR: prdata_q <= {28'h0, pwm_en_q};
                    default: begin
                        if (is_cmp(APB_IN.paddr)) begin
                            prdata_q <= cmp_q[cmp_idx(APB_IN.paddr)];
                        end
                    end
                endcase
            end
        end
    end

    assign APB_OUT.prdata = prdata_q;
    assign APB_OUT.pready = 1'b1;
    assign APB_OUT.pslverr = slverr_q & APB_IN.psel & APB_IN.penable;
    assign PWM_OUT = pwm_q;
    assign MATCH_IRQ_OUT = irq_q;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge CLK_IN);
    endclocking
    default disable iff (RESET_IN);

    property p_clear;
        clr_q |=> tc_q == 32'h0000_0000
            && (!clr_q || $past(wr_run && APB_IN.pwdata[MTPWM_CLR_BIT]));
    endproperty
    a_clear: assert property (p_clear) else $error("count clear failed");

    property p_hold;
        !run_q && !clr_q && !wr_tc |=> $stable(tc_q);
    endproperty
    a_hold: assert property (p_hold) else $error("count moved while stopped");

    // a channel that matches zero may still request, the wrap itself may not
    property p_wrap;
        step && !clr_q && !wr_tc && !restart_hit && !halt_hit
            && tc_q == 32'hFFFF_FFFF |=> tc_q == 32'h0000_0000
            ##1 (irq_q & ~$past(match & ie_bits)) == '0;
    endproperty
    a_wrap: assert property (p_wrap) else $error("count did not wrap");

    property p_timer;
        mode == MTPWM_TIMER && run_q && !clr_q && !wr_tc && !restart_hit
            && !halt_hit |=> tc_q == $past(tc_q) + 32'h0000_0001;
    endproperty
    a_timer: assert property (p_timer) else $error("timer mode did not count");

    property p_rise_mode;
        mode == MTPWM_RISE && run_q && !clr_q && !wr_tc
            && !($rose(u_edge.sync2_q)) |=> $stable(tc_q);
    endproperty
    a_rise_mode: assert property (p_rise_mode) else $error("counted without edge");

    property p_pick;
        mode != MTPWM_TIMER && src_q[MTPWM_PICK_LSB +: 2] != MTPWM_PICK_CAP0
            && !clr_q && !wr_tc |=> $stable(tc_q);
    endproperty
    a_pick: assert property (p_pick) else $error("reserved input counted");

    property p_halt;
        halt_hit && !wr_run && !clr_q && !wr_tc && !restart_hit |=> !run_q && $stable(tc_q);
    endproperty
    a_halt: assert property (p_halt) else $error("halt on match failed");

    property p_restart;
        restart_hit && !clr_q && !wr_tc |=> tc_q == 32'h0000_0000 && wrap_q;
    endproperty
    a_restart: assert property (p_restart) else $error("restart failed");

    property p_irq;
        tc_new_q && |(match & ie_bits) |=> irq_q == $past(match & ie_bits);
    endproperty
    a_irq: assert property (p_irq) else $error("match request missing");

    property p_rsv;
        setup && !APB_IN.pwrite && APB_IN.paddr == MTPWM_SRC_CTRL_ADDR
            |=> prdata_q[31:MTPWM_SRC_W] == '0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits not zero");

    for (genvar g = 0; g < MTPWM_NCH; g++) begin : g_pwm_chk
        property p_pwm_low;
            pwm_en_q[g] && wrap_q && cmp_q[g] != 32'h0000_0000 |=> !pwm_q[g];
        endproperty
        a_pwm_low: assert property (p_pwm_low) else $error("pwm not low");

        property p_pwm_high;
            pwm_en_q[g] && !wrap_q && match[g] && cmp_q[g] != 32'h0000_0000
                |=> pwm_q[g];
        endproperty
        a_pwm_high: assert property (p_pwm_high) else $error("pwm not set");

        property p_pwm_pulse;
            pwm_en_q[g] && restart_hit && match[g] && !clr_q
                && cmp_q[g] != 32'h0000_0000 |=> pwm_q[g] ##1 !pwm_q[g];
        endproperty
        a_pwm_pulse: assert property (p_pwm_pulse) else $error("pulse not one tick");

        property p_pwm_zero;
            pwm_en_q[g] && wrap_q && cmp_q[g] == 32'h0000_0000 |=> pwm_q[g];
        endproperty
        a_pwm_zero: assert property (p_pwm_zero) else $error("zero compare not high");
    end

endmodule

//--- tb/mtpwm_pins.sv
// Purpose: far-side model: drives the count input pin, watches PWM pins
// Assumes: same clock as the block, pin changes right after a rising edge
// Notes: pin idles low between pulse trains, the pin is always driven
`timescale 1ns/10ps
module mtpwm_pins (
    input wire logic clk_in,
    input wire logic [3:0] pwm_in,
    output logic cap_out
);
    int hi_cnt [4];

    initial begin
        cap_out = 1'b0;
    end

    // ****************************************
    // pulse train and pwm sampler
    // ****************************************
    // each level held half clocks, zero clocks if half is zero
    task automatic pulses(input int n, input int half);
        for (int i = 0; i < n; i++) begin
            cap_out <= 1'b1;
            repeat (half) @(posedge clk_in);
            cap_out <= 1'b0;
            repeat (half) @(posedge clk_in);
        end
    endtask

    // counts high cycles per output; window should be whole pwm periods
    task automatic measure(input int cycles);
        for (int c = 0; c < 4; c++) begin
            hi_cnt[c] = 0;
        end
        repeat (cycles) begin
            @(posedge clk_in);
            for (int c = 0; c < 4; c++) begin
                hi_cnt[c] += int'(pwm_in[c] === 1'b1);
            end
        end
    endtask
endmodule

//--- tb/mtpwm_top_tb.sv
// Purpose: self-checking bench for the match timer with pwm outputs
// Assumes: zero-wait apb slave, but waits on pready anyway
// Notes: counts of pwm high cycles are taken over two full periods
`timescale 1ns/10ps
`define CHK(g, e) check(32'(g), 32'(e))
module mtpwm_top_tb;
    import mtpwm_pkg::*;
    logic clk;
    logic rst;
    logic cap;
    logic err;
    logic [3:0] pwm;
    logic [3:0] irq;
    logic [31:0] rv;
    int n;
    int n_mismatch = 0;
    int cmp_count = 0;
    mtpwm_apb_req_t req;
    mtpwm_apb_rsp_t rsp;
    localparam logic [7:0] RUN = MTPWM_RUN_CTRL_ADDR;
    localparam logic [7:0] CNT = MTPWM_COUNT_ADDR;
    localparam logic [7:0] SRC = MTPWM_SRC_CTRL_ADDR;
    localparam logic [7:0] MACT = MTPWM_MATCH_CTRL_ADDR;
    localparam logic [7:0] CMP = MTPWM_CMP0_ADDR;

    mtpwm_top dut (
        .CLK_IN(clk),
        .RESET_IN(rst),
        .APB_IN(req),
        .APB_OUT(rsp),
        .CAP_IN(cap),
        .PWM_OUT(pwm),
        .MATCH_IRQ_OUT(irq)
    );

    mtpwm_pins pins (
        .clk_in(clk),
        .pwm_in(pwm),
        .cap_out(cap)
    );

    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t got %h exp %h", $time, g, e);
        end
    endtask

    // one transfer; request held until pready seen at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        req.psel <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite <= w;
        req.paddr <= a;
        req.pwdata <= d;
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (rsp.pready !== 1'b1 && k < 50);
        rv = rsp.prdata;
        err = rsp.pslverr;
        if (k == 50) n_mismatch++;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic wait_irq(input int ch);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (irq[ch] !== 1'b1 && n < 300);
        if (irq[ch] !== 1'b1) n_mismatch++;
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs;
        apb(1'b0, RUN, 0);
        `CHK(rv, 0);
        apb(1'b0, CNT, 0);
        `CHK(rv, 0);
        apb(1'b0, 8'h08, 0);
        `CHK(err, 1);
        `CHK(rv, 0);
        wr(SRC, 32'hFFFF_FFFF);
        apb(1'b0, SRC, 0);
        `CHK(rv, 32'h0000_000F);
        `CHK(err, 0);
        wr(MACT, 32'hFFFF_FFFF);
        apb(1'b0, MACT, 0);
        `CHK(rv, 32'h0000_0FFF);
        wr(MACT, 0);
        wr(SRC, 0);
        wr(CNT, 32'h0000_0064);
        repeat (5) @(posedge clk);
        apb(1'b0, CNT, 0);
        `CHK(rv, 32'h0000_0064);
        wr(RUN, 32'h0000_0002);
        apb(1'b0, RUN, 0);
        `CHK(rv, 0);
        apb(1'b0, CNT, 0);
        `CHK(rv, 0);
        $display("test regs done");
    endtask

    task automatic t_restart;
        wr(CMP, 32'h0000_0006);
        wr(MACT, 32'h0000_0003);
        wr(RUN, 32'h0000_0001);
        wait_irq(0);
        wait_irq(0);
        `CHK(n, 7);
        wr(RUN, 0);
        wr(MACT, 32'h0000_0028);
        wr(CMP + 8'h04, 32'h0000_0014);
        wr(RUN, 32'h0000_0002);
        wr(RUN, 32'h0000_0001);
        wait_irq(1);
        apb(1'b0, RUN, 0);
        `CHK(rv, 0);
        apb(1'b0, CNT, 0);
        `CHK(rv, 32'h0000_0014);
        wr(MACT, 32'h0000_0040);
        wr(CMP + 8'h08, 0);
        wr(CNT, 32'hFFFF_FFFE);
        wr(RUN, 32'h0000_0001);
        wait_irq(2);
        `CHK(n, 3);
        wr(RUN, 0);
        $display("test match done");
    endtask

    task automatic t_pwm;
        wr(MACT, 32'h0000_0400);
        wr(CMP + 8'h0C, 32'h0000_000A);
        wr(CMP, 32'h0000_0004);
        wr(CMP + 8'h04, 32'h0000_000A);
        wr(CMP + 8'h08, 0);
        wr(MTPWM_PWM_EN_ADDR, 32'h0000_0007);
        wr(RUN, 32'h0000_0002);
        wr(RUN, 32'h0000_0001);
        repeat (30) @(posedge clk);
        pins.measure(22);
        `CHK(pins.hi_cnt[0], 14);
        `CHK(pins.hi_cnt[1], 2);
        `CHK(pins.hi_cnt[2], 22);
        `CHK(pins.hi_cnt[3], 0);
        wr(CMP, 32'h0000_0032);
        repeat (25) @(posedge clk);
        pins.measure(22);
        `CHK(pins.hi_cnt[0], 0);
        `CHK(pins.hi_cnt[1], 2);
        wr(RUN, 0);
        wr(MACT, 0);
        $display("test pwm done");
    endtask

    // capture pick stays at zero here except in the last pass, which selects reserved input 1
    task automatic t_counter;
        for (int m = 1; m < 5; m++) begin
            wr(SRC, (m == 4) ? 32'h0000_0005 : 32'(m));
            wr(RUN, 32'h0000_0002);
            wr(RUN, 32'h0000_0001);
            pins.pulses(5, 3);
            repeat (8) @(posedge clk);
            apb(1'b0, CNT, 0);
            `CHK(rv, (m == 4) ? 0 : ((m == 3) ? 10 : 5));
        end
        $display("test counter done");
    endtask

    task automatic finish_test;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ****************************************
    // clock, reset, sequence, watchdog
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    initial begin
        rst = 1'b1;
        req = '0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_restart();
        t_pwm();
        t_counter();
        finish_test();
    end

    // the sequence needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        finish_test();
    end
endmodule
